// ---- bench/ebs_mem_model.sv ----
// Purpose: Behavioural synchronous memory on the far side of the bus engine.
// Assumes: Control and address lines only change on bus clock falls.
// Notes:   Stalls with wait for a planned number of data-phase rises.
`timescale 1ns/100ps
`default_nettype none
module ebs_mem_model (
    // Bus from the engine
    input  wire logic        sys_clk,
    input  wire logic        bus_clk,
    input  wire logic        cs_n,
    input  wire logic        oe_n,
    input  wire logic        adv_n,
    input  wire logic [3:0]  be_n,
    input  wire logic [9:0]  addr_hi,
    input  wire logic [15:0] ad_o,
    input  wire logic [31:0] data_o,
    // Test plan
    input  wire logic        mux,
    input  wire logic [1:0]  stall,
    // Device drive
    output logic      [15:0] dev_ad,
    output logic      [31:0] dev_data,
    output var logic         wait_n_q,
    // What the device saw
    output var logic  [25:0] seen_addr,
    output var logic  [31:0] seen_wdata,
    output var logic  [3:0]  seen_be_n
);
    logic [15:0] rel_cnt = 16'h0000;
    logic [1:0]  stall_left = 2'h0;
    logic [31:0] rd;
    initial wait_n_q = 1'b1;
    //////////////////////////////////////////////////////////////////////////
    // Released lines carry a count that changes every cycle so a stale value never looks valid.
    always @(posedge sys_clk) rel_cnt <= rel_cnt + 16'h0001;
    assign rd = {~seen_addr[15:0], seen_addr[15:0] ^ 16'h5a3c};
    always_comb begin
        dev_data = {~rel_cnt, rel_cnt};
        dev_ad   = rel_cnt ^ 16'h00ff;
        if (!cs_n && !oe_n) begin
            dev_data = {rd[31:16], mux ? ~rel_cnt : rd[15:0]};
            if (mux) begin
                dev_ad = rd[15:0];
            end
        end
    end
    //////////////////////////////////////////////////////////////////////////
    // Everything is taken at the rise; wait only moves at the fall.
    always @(posedge bus_clk) begin
        if (!cs_n && !adv_n) begin
            seen_addr  <= {addr_hi, ad_o};
            stall_left <= stall;
        end else if (!cs_n) begin
            if (stall_left != 2'h0) begin
                stall_left <= stall_left - 2'h1;
            end else begin
                seen_wdata <= {data_o[31:16], mux ? ad_o : data_o[15:0]};
                seen_be_n  <= be_n;
            end
        end
    end
    always @(negedge bus_clk) wait_n_q <= (stall_left == 2'h0);
endmodule
`default_nettype wire

// ---- bench/ext_bus_sync_timing_bench.sv ----
// Purpose: Self-checking bench of the synchronous external bus engine.
// Assumes: Clock enable stays high; one access at a time.
// Notes:   Random accesses over all divide, size and mux settings.
`timescale 1ns/100ps
`default_nettype none
`define EBS_CHECK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin bad_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module ext_bus_sync_timing_bench;
    logic sys_clk = 1'b0, nrst = 1'b0, mux = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic [1:0]  div = 2'h0, stall_plan = 2'h0;
    logic [2:0]  size = 3'h3;
    logic [25:0] req_addr = 26'h000_0000;
    logic [31:0] req_wdata = 32'h0000_0000, resp_rdata_q, data_o_q, data_i, dev_data, wdat;
    logic [3:0]  req_be = 4'h0, byte_enable_n_q, data_oe_q, seen_be_n;
    logic        req_ready_q, resp_valid_q, bus_clk_o, chip_select_n_q, write_enable_n_q;
    logic        output_enable_n_q, address_valid_n_q, ad_oe_q, wait_n_q, bclk_pv, last_cs;
    logic        cur_w = 1'b0;
    logic [6:0]  exp_drv, seen_drv;
    logic [9:0]  addr_hi_q;
    logic [15:0] ad_o_q, ad_i, dev_ad;
    logic [25:0] seen_addr;
    logic [31:0] seen_wdata;
    logic [70:0] vec, vec_pv;
    logic [2:0]  size_tab [8] = '{3'h1, 3'h3, 3'h2, 3'h4, 3'h5, 3'h7, 3'h0, 3'h6};
    int bad_count = 0, total_checks = 0, cyc = 0, seed_dummy, exp_per;
    always #5 sys_clk = ~sys_clk;
    ebs_sync_bus ebs_sync_bus_i (.sys_clk(sys_clk), .nrst(nrst), .ce(1'b1),
        .clk_div_field(div), .addr_data_mux_select(mux), .data_size_field(size),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_be(req_be), .req_ready_q(req_ready_q),
        .resp_valid_q(resp_valid_q), .resp_rdata_q(resp_rdata_q), .bus_clk_o(bus_clk_o),
        .chip_select_n_q(chip_select_n_q), .write_enable_n_q(write_enable_n_q),
        .output_enable_n_q(output_enable_n_q), .byte_enable_n_q(byte_enable_n_q),
        .address_valid_n_q(address_valid_n_q), .addr_hi_q(addr_hi_q), .ad_o_q(ad_o_q),
        .ad_oe_q(ad_oe_q), .ad_i(ad_i), .data_o_q(data_o_q), .data_oe_q(data_oe_q),
        .data_i(data_i), .wait_n(wait_n_q));
    ebs_mem_model ebs_mem_model_i (.sys_clk(sys_clk), .bus_clk(bus_clk_o),
        .cs_n(chip_select_n_q), .oe_n(output_enable_n_q), .adv_n(address_valid_n_q),
        .be_n(byte_enable_n_q), .addr_hi(addr_hi_q), .ad_o(ad_o_q), .data_o(data_o_q),
        .mux(mux), .stall(stall_plan), .dev_ad(dev_ad), .dev_data(dev_data),
        .wait_n_q(wait_n_q), .seen_addr(seen_addr), .seen_wdata(seen_wdata),
        .seen_be_n(seen_be_n));
    //////////////////////////////////////////////////////////////////////////
    // Each shared line carries whoever enables it.
    always_comb begin
        ad_i = ad_oe_q ? ad_o_q : dev_ad;
        for (int k = 0; k < 4; k++) begin
            data_i[8*k +: 8] = data_oe_q[k] ? data_o_q[8*k +: 8] : dev_data[8*k +: 8];
        end
    end
    function automatic logic [3:0] lanes(input logic [2:0] s);
        case (s)
            ebs_pkg::SIZE_16_LO: return ebs_pkg::LANES_16_LO;
            ebs_pkg::SIZE_16_HI: return ebs_pkg::LANES_16_HI;
            ebs_pkg::SIZE_32:    return ebs_pkg::LANES_ALL;
            ebs_pkg::SIZE_8_L0:  return ebs_pkg::LANES_L0;
            ebs_pkg::SIZE_8_L1:  return ebs_pkg::LANES_L1;
            ebs_pkg::SIZE_8_L3:  return ebs_pkg::LANES_L3;
            default:             return ebs_pkg::LANES_NONE;
        endcase
    endfunction
    //////////////////////////////////////////////////////////////////////////
    // Pin outputs may only move where the bus clock falls; rises while chip select stays low are spaced evenly.
    always @(negedge sys_clk) begin
        vec = {chip_select_n_q, write_enable_n_q, output_enable_n_q, byte_enable_n_q,
               address_valid_n_q, addr_hi_q, ad_o_q, ad_oe_q, data_o_q, data_oe_q};
        cyc++;
        if (nrst) begin
            if (vec !== vec_pv)
                `EBS_CHECK("output edge", 2'b10, {bclk_pv, bus_clk_o})
            if (bclk_pv === 1'b0 && bus_clk_o === 1'b1) begin
                exp_per = (int'(div) + 1) * ebs_pkg::LOGIC_TICK_CYC;
                if (last_cs === 1'b0 && chip_select_n_q === 1'b0)
                    `EBS_CHECK("bus period", exp_per, cyc)
                last_cs = chip_select_n_q;
                cyc = 0;
            end
            // In the data phase one strobe is low and only the lanes being written are driven.
            if (chip_select_n_q === 1'b0 && address_valid_n_q === 1'b1) begin
                exp_drv[6:4] = {~cur_w, cur_w, !mux || cur_w};
                exp_drv[3:0] = !cur_w ? 4'h0 : !mux ? lanes(size)
                             : (size == ebs_pkg::SIZE_32) ? 4'hc : 4'h0;
                seen_drv = {write_enable_n_q, output_enable_n_q, ad_oe_q, data_oe_q};
                `EBS_CHECK("data drive", exp_drv, seen_drv)
            end
        end else begin
            last_cs = 1'b1;
        end
        vec_pv = vec;
        bclk_pv = bus_clk_o;
    end
    //////////////////////////////////////////////////////////////////////////
    task automatic access(input logic w, input logic [1:0] d, input logic m,
                          input logic [2:0] sz, input logic [1:0] st);
        logic [3:0]  ln;
        logic [31:0] msk;
        logic [25:0] a;
        int          n;
        ln  = lanes(sz);
        msk = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
        a   = 26'($urandom);
        @(posedge sys_clk);
        #1;
        {div, mux, size, stall_plan, req_write, req_addr} = {d, m, sz, st, w, a};
        cur_w     = w;
        req_wdata = $urandom;
        req_be    = 4'($urandom);
        req_valid = 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (req_ready_q !== 1'b1 && n < 50);
        // Held requests while busy must leave the running access untouched.
        #1;
        req_addr  = ~a;
        req_write = ~w;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (resp_valid_q !== 1'b1 && n < 3000);
        req_valid = 1'b0;
        `EBS_CHECK("resp valid", 1'b1, resp_valid_q)
        `EBS_CHECK("ready", 1'b1, req_ready_q)
        `EBS_CHECK("address", a, seen_addr)
        `EBS_CHECK("byte enables", ~(req_be & ln), seen_be_n)
        if (w) begin
            wdat = req_wdata;
            `EBS_CHECK("write data", wdat & msk, seen_wdata & msk)
        end else begin
            wdat = {~a[15:0], a[15:0] ^ 16'h5a3c} & msk;
            `EBS_CHECK("read data", wdat, resp_rdata_q)
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #400000;
        bad_count++;
        end_sim();
    end
    initial begin
        int i;
        seed_dummy = $urandom(32'hfb1d);
        repeat (8) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        #2;
        `EBS_CHECK("idle pins", 10'h3fc, {chip_select_n_q, write_enable_n_q, output_enable_n_q,
            byte_enable_n_q, address_valid_n_q, bus_clk_o, ad_oe_q})
        `EBS_CHECK("idle ready", 1'b1, req_ready_q)
        for (int d = 0; d < 4; d++) begin
            for (int w = 0; w < 2; w++) begin
                for (i = 0; i < 8; i++) begin
                    access(w[0], d[1:0], (i < 2) && (d[0] ^ w[0]), size_tab[i], i[1:0]);
                end
            end
        end
        for (i = 0; i < 120; i++) begin
            mux = 1'($urandom);
            access(1'($urandom), 2'($urandom), mux,
                   size_tab[mux ? $urandom % 2 : $urandom % 8], 2'($urandom));
        end
        end_sim();
    end
endmodule
`default_nettype wire

// ---- rtl/ebs_bclk_div.sv ----
// Purpose: Bus clock divider with rise and fall strobes.
// Assumes: Half period of the bus clock is (div + 1) system clock cycles.
// Notes:   Strobes mark the system clock edge on which the bus clock changes.
`timescale 1ns/100ps
`default_nettype none
module ebs_bclk_div (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   nrst,
    input  wire logic                   ce,
    // Control
    input  wire logic [ebs_pkg::DIV_W-1:0] div,
    input  wire logic                   restart,
    // Bus clock and edge strobes
    output logic                        bus_clk_q,
    output logic                        rise_nxt,
    output logic                        fall_nxt
);

    logic [3:0] half;
    logic [3:0] cnt_q;
    logic [3:0] hcnt_q;

    assign half     = 4'((32'(div) + 1) * ebs_pkg::LOGIC_TICK_CYC / 2 * 1);
    assign rise_nxt = ce && (restart || cnt_q == 4'((2 * half) - 1));
    assign fall_nxt = ce && !restart && cnt_q == 4'(half - 1);

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 4'h0;
        end else if (rise_nxt) begin
            cnt_q <= 4'h0;
        end else if (ce) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // Period is 2 * half system cycles, i.e. (div + 1) logic ticks.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bus_clk_q <= 1'b0;
        end else if (rise_nxt) begin
            bus_clk_q <= 1'b1;
        end else if (fall_nxt) begin
            bus_clk_q <= 1'b0;
        end
    end

    // Counts enabled cycles since the last rising edge, for checking only.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hcnt_q <= 4'h0;
        end else if (rise_nxt) begin
            hcnt_q <= 4'h0;
        end else if (ce && hcnt_q != 4'hf) begin
            hcnt_q <= hcnt_q + 4'h1;
        end
    end

    a_div_period: assert property (@(posedge sys_clk) disable iff (!nrst)
        (rise_nxt && !restart)
        |-> int'(hcnt_q) == (int'(div) + 1) * ebs_pkg::LOGIC_TICK_CYC - 1)
        else $error("bus clock period does not match divide setting");

    a_div_restart: assert property (@(posedge sys_clk) disable iff (!nrst)
        (ce && restart) |=> (cnt_q == 4'h0 && bus_clk_q))
        else $error("divider did not restart from its first phase");

endmodule
`default_nettype wire

// ---- rtl/ebs_pkg.sv ----
// Purpose: Shared constants and types of the synchronous external bus engine.
// Assumes: One system clock; the logic-clock tick is two system clock cycles.
// Notes:   Data size codes select which byte lanes of the external bus are wired.
package ebs_pkg;

    // Bus widths.
    localparam int ADDR_W    = 26;
    localparam int ADDR_HI_W = 10;
    localparam int AD_W      = 16;
    localparam int DATA_W    = 32;
    localparam int BE_W      = 4;
    localparam int DIV_W     = 2;
    localparam int SIZE_W    = 3;

    // One logic-clock period t spans this many system clock cycles.
    localparam int LOGIC_TICK_CYC = 2;

    // Pin input synchroniser depth.
    localparam int SYNC_DEPTH = 3;

    // Data size codes.
    localparam logic [2:0] SIZE_16_LO  = 3'h1;
    localparam logic [2:0] SIZE_16_HI  = 3'h2;
    localparam logic [2:0] SIZE_32     = 3'h3;
    localparam logic [2:0] SIZE_8_L0   = 3'h4;
    localparam logic [2:0] SIZE_8_L1   = 3'h5;
    localparam logic [2:0] SIZE_8_L3   = 3'h7;

    // Lane masks per data size.
    localparam logic [3:0] LANES_NONE  = 4'h0;
    localparam logic [3:0] LANES_16_LO = 4'h3;
    localparam logic [3:0] LANES_16_HI = 4'hc;
    localparam logic [3:0] LANES_ALL   = 4'hf;
    localparam logic [3:0] LANES_L0    = 4'h1;
    localparam logic [3:0] LANES_L1    = 4'h2;
    localparam logic [3:0] LANES_L3    = 4'h8;

    typedef enum logic [1:0] {
        EBS_IDLE,
        EBS_ADDR,
        EBS_DATA,
        EBS_DONE
    } ebs_state_t;

endpackage

// ---- rtl/ebs_sync_bus.sv ----
// Purpose: Synchronous external memory bus engine, one access at a time.
// Assumes: Bus pins are sampled through a three-stage synchroniser.
// Notes:   Outputs change only on bus clock falls; inputs are taken at rises.
//
// Behaviour
// - Every control output is switched by logic aligned to the bus clock.
// - Bus clock period equals logic period times divide setting plus one.
// - Address, selects, enables and write data are valid half period before rise.
// - Those outputs change half a period after rise, at the bus clock fall.
// - Read data and wait are sampled at the rising bus clock edge.
// - Multiplexed 32-bit mode puts the upper 16 data bits on the data bus.
// - Eight and sixteen bit devices, separate or multiplexed, by mode and size.
`timescale 1ns/100ps
`default_nettype none
module ebs_sync_bus #(
    parameter int ADDR_W = ebs_pkg::ADDR_W,
    parameter int DATA_W = ebs_pkg::DATA_W
) (
    // Clock, reset and enable
    input  wire logic                         sys_clk,
    input  wire logic                         nrst,
    input  wire logic                         ce,
    // Static configuration
    input  wire logic [ebs_pkg::DIV_W-1:0]    clk_div_field,
    input  wire logic                         addr_data_mux_select,
    input  wire logic [ebs_pkg::SIZE_W-1:0]   data_size_field,
    // Access request
    input  wire logic                         req_valid,
    input  wire logic                         req_write,
    input  wire logic [ADDR_W-1:0]            req_addr,
    input  wire logic [DATA_W-1:0]            req_wdata,
    input  wire logic [ebs_pkg::BE_W-1:0]     req_be,
    output logic                              req_ready_q,
    // Access response
    output logic                              resp_valid_q,
    output logic [DATA_W-1:0]                 resp_rdata_q,
    // External bus
    output logic                              bus_clk_o,
    output logic                              chip_select_n_q,
    output logic                              write_enable_n_q,
    output logic                              output_enable_n_q,
    output logic [ebs_pkg::BE_W-1:0]          byte_enable_n_q,
    output logic                              address_valid_n_q,
    output logic [ebs_pkg::ADDR_HI_W-1:0]     addr_hi_q,
    output logic [ebs_pkg::AD_W-1:0]          ad_o_q,
    output logic                              ad_oe_q,
    input  wire logic [ebs_pkg::AD_W-1:0]     ad_i,
    output logic [DATA_W-1:0]                 data_o_q,
    output logic [ebs_pkg::BE_W-1:0]          data_oe_q,
    input  wire logic [DATA_W-1:0]            data_i,
    input  wire logic                         wait_n
);

    localparam int IN_W = 1 + ebs_pkg::AD_W + DATA_W;

    ebs_pkg::ebs_state_t st_q;
    ebs_pkg::ebs_state_t drv_q;
    ebs_pkg::ebs_state_t ph_dl_q [ebs_pkg::SYNC_DEPTH];
    logic [2:0]          rise_dl_q;
    logic                rise_nxt;
    logic                fall_nxt;
    logic                restart;
    logic [1:0]          div_q;
    logic                wr_q;
    logic                mux_q;
    logic [2:0]          size_q;
    logic [ADDR_W-1:0]   addr_q;
    logic [DATA_W-1:0]   wdata_q;
    logic [3:0]          be_q;
    logic [3:0]          lanes;
    logic [IN_W-1:0]     pin_s_q [ebs_pkg::SYNC_DEPTH];
    logic [IN_W-1:0]     pin_st_q;
    logic [IN_W-1:0]     pin_eff;
    logic                samp;
    logic                accept;

    ////////////////////////////////////////////////////////////////////////////
    // Bus clock.

    assign accept  = ce && req_ready_q && req_valid;
    assign restart = accept || (ce && clk_div_field != div_q);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            div_q <= 2'h0;
        end else if (ce) begin
            div_q <= clk_div_field;
        end
    end

    ebs_bclk_div u_div (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .ce       (ce),
        .div      (clk_div_field),
        .restart  (restart),
        .bus_clk_q(bus_clk_o),
        .rise_nxt (rise_nxt),
        .fall_nxt (fall_nxt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pin inputs: three stages; a bit changes once stages two and three agree.

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < ebs_pkg::SYNC_DEPTH; i++) begin
                pin_s_q[i] <= '0;
            end
            pin_st_q <= '0;
        end else if (ce) begin
            pin_s_q[0] <= {wait_n, ad_i, data_i};
            pin_s_q[1] <= pin_s_q[0];
            pin_s_q[2] <= pin_s_q[1];
            pin_st_q   <= pin_eff;
        end
    end

    assign pin_eff = (pin_s_q[2] & ~(pin_s_q[1] ^ pin_s_q[2]))
                   | (pin_st_q & (pin_s_q[1] ^ pin_s_q[2]));

    // The rise strobe and the bus phase follow the pins through equal delay,
    // so each sample is paired with what the bus showed at that rising edge.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rise_dl_q <= 3'h0;
            for (int i = 0; i < ebs_pkg::SYNC_DEPTH; i++) begin
                ph_dl_q[i] <= ebs_pkg::EBS_IDLE;
            end
        end else if (ce) begin
            rise_dl_q  <= {rise_dl_q[1:0], rise_nxt};
            ph_dl_q[0] <= drv_q;
            ph_dl_q[1] <= ph_dl_q[0];
            ph_dl_q[2] <= ph_dl_q[1];
        end
    end

    assign samp = ce && rise_dl_q[2];

    ////////////////////////////////////////////////////////////////////////////
    // Request capture.

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_q    <= 1'b0;
            mux_q   <= 1'b0;
            size_q  <= 3'h0;
            addr_q  <= '0;
            wdata_q <= '0;
            be_q    <= 4'h0;
        end else if (accept) begin
            wr_q    <= req_write;
            mux_q   <= addr_data_mux_select;
            size_q  <= data_size_field;
            addr_q  <= req_addr;
            wdata_q <= req_wdata;
            be_q    <= req_be;
        end
    end

    always_comb begin
        unique case (size_q)
            ebs_pkg::SIZE_16_LO: lanes = ebs_pkg::LANES_16_LO;
            ebs_pkg::SIZE_16_HI: lanes = ebs_pkg::LANES_16_HI;
            ebs_pkg::SIZE_32:    lanes = ebs_pkg::LANES_ALL;
            ebs_pkg::SIZE_8_L0:  lanes = ebs_pkg::LANES_L0;
            ebs_pkg::SIZE_8_L1:  lanes = ebs_pkg::LANES_L1;
            ebs_pkg::SIZE_8_L3:  lanes = ebs_pkg::LANES_L3;
            default:             lanes = ebs_pkg::LANES_NONE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access sequence. Steps are decided on samples, acted on at the next fall.

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= ebs_pkg::EBS_IDLE;
        end else if (accept) begin
            st_q <= ebs_pkg::EBS_ADDR;
        end else if (samp && ph_dl_q[2] == st_q) begin
            unique case (st_q)
                ebs_pkg::EBS_ADDR: st_q <= ebs_pkg::EBS_DATA;
                ebs_pkg::EBS_DATA: begin
                    if (pin_eff[IN_W-1]) begin
                        st_q <= ebs_pkg::EBS_DONE;
                    end
                end
                ebs_pkg::EBS_IDLE,
                ebs_pkg::EBS_DONE: st_q <= st_q;
            endcase
        end else if (fall_nxt && st_q == ebs_pkg::EBS_DONE) begin
            st_q <= ebs_pkg::EBS_IDLE;
        end
    end

    // Read data captured at the rise that ends the data phase.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            resp_rdata_q <= '0;
        end else if (samp && st_q == ebs_pkg::EBS_DATA && ph_dl_q[2] == st_q
                     && pin_eff[IN_W-1] && !wr_q) begin
            for (int b = 0; b < 4; b++) begin
                resp_rdata_q[8*b +: 8] <= lanes[b] ? pin_eff[8*b +: 8] : 8'h00;
            end
            if (mux_q) begin
                resp_rdata_q[15:0] <= pin_eff[DATA_W +: 16];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            req_ready_q  <= 1'b1;
            resp_valid_q <= 1'b0;
        end else if (ce) begin
            resp_valid_q <= fall_nxt && st_q == ebs_pkg::EBS_DONE;
            if (accept) begin
                req_ready_q <= 1'b0;
            end else if (fall_nxt && st_q == ebs_pkg::EBS_DONE) begin
                req_ready_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive, switched only on bus clock falls.

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            drv_q             <= ebs_pkg::EBS_IDLE;
            chip_select_n_q   <= 1'b1;
            address_valid_n_q <= 1'b1;
            write_enable_n_q  <= 1'b1;
            output_enable_n_q <= 1'b1;
            byte_enable_n_q   <= 4'hf;
            addr_hi_q         <= '0;
            ad_o_q            <= '0;
            ad_oe_q           <= 1'b0;
            data_o_q          <= '0;
            data_oe_q         <= 4'h0;
        end else if (fall_nxt) begin
            drv_q             <= (st_q == ebs_pkg::EBS_DONE) ? ebs_pkg::EBS_IDLE : st_q;
            chip_select_n_q   <= !(st_q == ebs_pkg::EBS_ADDR || st_q == ebs_pkg::EBS_DATA);
            address_valid_n_q <= !(st_q == ebs_pkg::EBS_ADDR);
            write_enable_n_q  <= !(st_q == ebs_pkg::EBS_DATA && wr_q);
            output_enable_n_q <= !(st_q == ebs_pkg::EBS_DATA && !wr_q);
            byte_enable_n_q   <= (st_q == ebs_pkg::EBS_DATA) ? ~(be_q & lanes) : 4'hf;
            addr_hi_q         <= addr_q[ADDR_W-1:ebs_pkg::AD_W];
            data_o_q          <= wdata_q;
            if (mux_q && st_q == ebs_pkg::EBS_DATA) begin
                ad_o_q  <= wdata_q[15:0];
                ad_oe_q <= wr_q;
                // Upper half rides the separate data lanes.
                data_oe_q <= (wr_q && size_q == ebs_pkg::SIZE_32) ? 4'hc : 4'h0;
            end else begin
                ad_o_q    <= addr_q[15:0];
                ad_oe_q   <= st_q == ebs_pkg::EBS_ADDR || (!mux_q && st_q == ebs_pkg::EBS_DATA);
                data_oe_q <= (!mux_q && wr_q && st_q == ebs_pkg::EBS_DATA) ? lanes : 4'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_ctrl_on_fall: assert property (@(posedge sys_clk) disable iff (!nrst)
        ($changed(chip_select_n_q) || $changed(write_enable_n_q)
         || $changed(output_enable_n_q) || $changed(address_valid_n_q)) |-> $fell(bus_clk_o))
        else $error("control output changed away from a bus clock fall");

    a_addr_setup: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(bus_clk_o) |-> ($stable(addr_hi_q) && $stable(byte_enable_n_q)
                              && $stable(data_o_q) && $stable(ad_o_q)))
        else $error("bus output changed at a rising edge");

    a_data_on_fall: assert property (@(posedge sys_clk) disable iff (!nrst)
        ($changed(data_oe_q) || $changed(ad_oe_q)) |-> !bus_clk_o && $past(bus_clk_o))
        else $error("data drive changed away from a bus clock fall");

    a_wait_sampled: assert property (@(posedge sys_clk) disable iff (!nrst)
        ($past(st_q) == ebs_pkg::EBS_DATA && st_q == ebs_pkg::EBS_DONE)
        |-> $past(samp) && $past(pin_eff[IN_W-1]))
        else $error("data phase ended without a rising-edge sample of wait");

    a_mux_upper: assert property (@(posedge sys_clk) disable iff (!nrst)
        (fall_nxt && st_q == ebs_pkg::EBS_DATA && mux_q && wr_q
         && size_q == ebs_pkg::SIZE_32) |=> data_oe_q == 4'hc && ad_oe_q)
        else $error("upper half not driven on data lanes in multiplexed mode");

    a_sep_addr: assert property (@(posedge sys_clk) disable iff (!nrst)
        (!mux_q && !chip_select_n_q) |-> ad_oe_q && ad_o_q == addr_q[15:0])
        else $error("address lines not driven during a separate-mode access");

    a_addr_first: assert property (@(posedge sys_clk) disable iff (!nrst)
        $fell(chip_select_n_q) |-> !address_valid_n_q && ad_oe_q)
        else $error("access did not open with an address phase");

    a_resp_one: assert property (@(posedge sys_clk) disable iff (!nrst)
        resp_valid_q |-> chip_select_n_q && req_ready_q ##1 !resp_valid_q)
        else $error("response not paired with released chip select");

endmodule
`default_nettype wire
